// File: hdl/iodiag_map.svh
`ifndef IODIAG_MAP_SVH
`define IODIAG_MAP_SVH

// Register byte offsets on the Wishbone slave.
`define IODIAG_OFS_CMD      8'h00
`define IODIAG_OFS_DATA     8'h04
`define IODIAG_OFS_EXEC     8'h08
`define IODIAG_OFS_REPLY    8'h0c
`define IODIAG_OFS_STATUS   8'h10

// Command codes and data numbers.
`define IODIAG_CMD_READ_MODE  8'h00
`define IODIAG_DNO_READ_MODE  8'h12
`define IODIAG_CMD_IO_READ    8'h12
`define IODIAG_DNO_IN_DEV     8'h00
`define IODIAG_DNO_IN_PIN     8'h40
`define IODIAG_DNO_LINK_DEV   8'h60
`define IODIAG_DNO_OUT_DEV    8'h80
`define IODIAG_DNO_OUT_PIN    8'hc0
`define IODIAG_CMD_DISABLE    8'h90
`define IODIAG_DNO_IN_OFF     8'h00
`define IODIAG_DNO_IN_ON      8'h10
`define IODIAG_DNO_OUT_OFF    8'h03
`define IODIAG_DNO_OUT_ON     8'h13
`define IODIAG_CMD_DEV_WRITE  8'h92
`define IODIAG_DNO_TEST_DEV   8'h00
`define IODIAG_CMD_TEST_SEL   8'h8b
`define IODIAG_DNO_TEST_SEL   8'h00
`define IODIAG_CMD_POS_CTRL   8'ha0
`define IODIAG_DNO_POS_CTRL   8'h41

// Data values: unlock key and four-character strings, blanks as spaces.
`define IODIAG_KEY            32'h0000_1ea5
`define IODIAG_STR_STOP       32'h5354_4f50
`define IODIAG_STR_GO         32'h474f_2020
`define IODIAG_STR_CLEAR      32'h434c_5220

// Bitmap layouts.
`define IODIAG_IN_DEV_MASK    32'h3cd4_ffff
`define IODIAG_OUT_DEV_MASK   32'h8f20_8fbf
`define IODIAG_IN_KEEP_MASK   32'h0004_0006
`define IODIAG_IN_PIN_W       12
`define IODIAG_OUT_PIN_W      9
`define IODIAG_PULSE_BIT_LO   10
`define IODIAG_PULSE_BIT_HI   11

// Communication timeout during test operation.
`define IODIAG_TIMEOUT_MS     500
`define IODIAG_CLK_KHZ        100000

`endif

// File: hdl/iodiag_pkg.sv
package iodiag_pkg;

  // Test operation mode, coded as the mode read-back value.
  typedef enum logic [2:0] {
    IODIAG_NORMAL = 3'b000,
    IODIAG_JOG    = 3'b001,
    IODIAG_POSIT  = 3'b010,
    IODIAG_FORCE  = 3'b100
  } iodiag_mode_t;

  // Positioning motion control state.
  typedef enum logic [0:0] {
    IODIAG_POS_RUN  = 1'b0,
    IODIAG_POS_HELD = 1'b1
  } iodiag_pos_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } iodiag_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } iodiag_wb_rsp_t;

  typedef struct packed {
    logic         ack;
    logic [31:0]  rdat;
    logic [15:0]  cmd;
    logic [31:0]  data;
    logic [31:0]  reply;
    iodiag_mode_t mode;
    iodiag_pos_t  pos;
    logic         in_off;
    logic         out_off;
    logic [31:0]  link_dev;
    logic [31:0]  test_dev;
    logic [31:0]  tmo_cnt;
    logic         tmo_stop;
    logic         base_cut;
    logic         pos_stop;
    logic         pos_go;
    logic         pos_clr;
    logic [31:0]  in_eff;
  } iodiag_state_t;

endpackage

// File: hdl/iodiag_top.sv
// How it works
// R1: Command 12/00 returns the input device bitmap; servo on, stroke ends, reset.
// R2: Command 12/40 returns input pin states; only bits 0 to 11 are pins.
// R3: Pin bits 10 and 11 read zero when pulse-train input owns them.
// R4: Command 12/60 returns the link-driven input device bitmap.
// R5: Command 12/C0 returns output pin states; only bits 0 to 8 are pins.
// R6: Command 12/80 returns the output device bitmap; ready, in-position, warning, alarm.
// R7: Command 92/60 replaces all link-driven input devices with the received bitmap.
// R8: The master resends every device it wants kept on in each frame.
// R9: Disabled inputs read off, analog zero, no pulses; forced stop and strokes stay.
// R10: Command 90/00 with key disables inputs; 90/10 with key enables them.
// R11: Command 90/03 with key disables outputs; 90/13 with key enables them.
// R12: Command 92/00 loads the test-operation input devices.
// R13: Entering test mode is allowed while running and cuts the base circuit.
// R14: In test mode, 0.5 s without commands decelerates to stop and servo-lock.
// R15: The master keeps traffic flowing during test mode.
// R16: Command 8B/00 selects JOG 0001, positioning 0002 or forced output 0004.
// R17: Command 00/12 returns the current test mode code.
// R18: The master reads the mode back and checks it after selecting.
// R19: Command 8B/00 with 0000 returns to normal mode.
// R20: STOP during positioning decelerates to a temporary stop.
// R21: GO during a temporary stop resumes the positioning motion.
// R22: Clear string during a temporary stop ends positioning, dropping remaining travel.
// R23: Unassigned bits read zero and are ignored when written.
// R24: Stop, go and clear are ignored outside the state they apply to.
`include "iodiag_map.svh"
`timescale 1ns/100ps
`default_nettype none

module iodiag_top
  import iodiag_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = `IODIAG_TIMEOUT_MS * `IODIAG_CLK_KHZ
)
(
  input  wire logic                          clk,
  input  wire logic                          rst_b,
  input  wire iodiag_wb_req_t                wb_req,
  output var iodiag_wb_rsp_t                 wb_rsp,
  input  wire logic [`IODIAG_IN_PIN_W-1:0]   ext_in_pins,
  input  wire logic [1:0]                    pulse_train_sel,
  input  wire logic [31:0]                   pin_in_dev,
  input  wire logic [31:0]                   core_out_dev,
  input  wire logic [`IODIAG_OUT_PIN_W-1:0]  ext_out_pins,
  input  wire logic                          pos_motion_active,
  output logic [31:0]                        in_dev_effective,
  output logic                               analog_zero,
  output logic                               pulse_train_block,
  output logic                               out_dev_enable,
  output logic [2:0]                         test_mode,
  output logic                               base_cutoff,
  output logic                               decel_hold,
  output logic                               pos_stop_req,
  output logic                               pos_resume,
  output logic                               pos_clear
);

  iodiag_state_t st;
  iodiag_state_t next_st;

  logic          access;
  logic          exec;
  logic [7:0]    cmd_code;
  logic [7:0]    cmd_dno;
  logic          key_ok;
  logic [31:0]   in_pin_map;
  logic [31:0]   next_rdat;
  logic [31:0]   cmd_wr;

  // A new request is one that has not yet been acknowledged.
  assign access   = wb_req.cyc && wb_req.stb && !st.ack;
  assign exec     = access && wb_req.we && (wb_req.adr == `IODIAG_OFS_EXEC);
  assign cmd_code = st.cmd[15:8];
  assign cmd_dno  = st.cmd[7:0];
  assign key_ok   = (st.data == `IODIAG_KEY);

  // Pulse-train pins are owned by the pulse input, so their bits read off when pulse_train_sel selects them.
  always_comb
  begin
    in_pin_map = 32'h0000_0000;
    in_pin_map[`IODIAG_IN_PIN_W-1:0] = ext_in_pins;
    if (pulse_train_sel[0])
      in_pin_map[`IODIAG_PULSE_BIT_LO] = 1'b0; // see R3
    if (pulse_train_sel[1])
      in_pin_map[`IODIAG_PULSE_BIT_HI] = 1'b0; // see R3
  end

  // Byte-lane merge so partial writes touch only the selected bytes.
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
      if (sel[i])
        r[8*i +: 8] = new_v[8*i +: 8];
    return r;
  endfunction

  // The command word is merged at full width and cut to its 16 bits where it is stored.
  assign cmd_wr = merge({16'h0000, st.cmd}, wb_req.dat, wb_req.sel);

  // Register read mux; unmapped addresses answer with zero.
  always_comb
  begin
    case (wb_req.adr)
      `IODIAG_OFS_CMD:
        next_rdat = {16'h0000, st.cmd};
      `IODIAG_OFS_DATA:
        next_rdat = st.data;
      `IODIAG_OFS_REPLY:
        next_rdat = st.reply;
      `IODIAG_OFS_STATUS:
        next_rdat = {20'h00000, st.tmo_stop, st.out_off, st.in_off, st.pos, 5'h00,
                     st.mode};
      default:
        next_rdat = 32'h0000_0000;
    endcase
  end

  // All next-state logic for the command interpreter.
  always_comb
  begin
    next_st          = st;
    next_st.ack      = access;
    next_st.base_cut = 1'b0;
    next_st.pos_stop = 1'b0;
    next_st.pos_go   = 1'b0;
    next_st.pos_clr  = 1'b0;
    if (access && !wb_req.we)
      next_st.rdat = next_rdat;
    if (access && wb_req.we && wb_req.adr == `IODIAG_OFS_CMD)
      next_st.cmd = cmd_wr[15:0];
    if (access && wb_req.we && wb_req.adr == `IODIAG_OFS_DATA)
      next_st.data = merge(st.data, wb_req.dat, wb_req.sel);

    // Communication watchdog; only meaningful while in test operation.
    if (exec || st.mode == IODIAG_NORMAL)
    begin
      next_st.tmo_cnt  = 32'h0000_0000;
      next_st.tmo_stop = 1'b0;
    end
    else if (st.tmo_cnt >= 32'(TIMEOUT_CYCLES - 1))
    begin
      next_st.tmo_stop = 1'b1; // see R14
    end
    else
    begin
      next_st.tmo_cnt = st.tmo_cnt + 32'h0000_0001;
    end

    if (exec)
    begin
      case (cmd_code)
        `IODIAG_CMD_READ_MODE:
        begin
          if (cmd_dno == `IODIAG_DNO_READ_MODE)
            next_st.reply = {29'h0000_0000, st.mode}; // see R17
        end
        `IODIAG_CMD_IO_READ:
        begin
          case (cmd_dno)
            `IODIAG_DNO_IN_DEV:
              next_st.reply = st.in_eff & `IODIAG_IN_DEV_MASK; // see R1, R23
            `IODIAG_DNO_IN_PIN:
              next_st.reply = in_pin_map; // see R2, R3
            `IODIAG_DNO_LINK_DEV:
              next_st.reply = st.link_dev; // see R4
            `IODIAG_DNO_OUT_PIN:
              next_st.reply = {{(32-`IODIAG_OUT_PIN_W){1'b0}}, ext_out_pins}; // see R5
            `IODIAG_DNO_OUT_DEV:
              next_st.reply = core_out_dev & `IODIAG_OUT_DEV_MASK; // see R6, R23
            default:
              next_st.reply = st.reply;
          endcase
        end
        `IODIAG_CMD_DISABLE:
        begin
          if (key_ok)
          begin
            case (cmd_dno)
              `IODIAG_DNO_IN_OFF:
                next_st.in_off = 1'b1; // see R10
              `IODIAG_DNO_IN_ON:
                next_st.in_off = 1'b0; // see R10
              `IODIAG_DNO_OUT_OFF:
                next_st.out_off = 1'b1; // see R11
              `IODIAG_DNO_OUT_ON:
                next_st.out_off = 1'b0; // see R11
              default:
                next_st.in_off = st.in_off;
            endcase
          end
        end
        `IODIAG_CMD_DEV_WRITE:
        begin
          // Whole-map replace: a device left out of a frame turns off.
          if (cmd_dno == `IODIAG_DNO_LINK_DEV)
          begin
            next_st.link_dev = st.data & `IODIAG_IN_DEV_MASK; // see R7, R8, R23
          end
          else if (cmd_dno == `IODIAG_DNO_TEST_DEV)
          begin
            next_st.test_dev = st.data & `IODIAG_IN_DEV_MASK; // see R12, R23
          end
        end
        `IODIAG_CMD_TEST_SEL:
        begin
          if (cmd_dno == `IODIAG_DNO_TEST_SEL)
          begin
            case (st.data)
              32'h0000_0000:
              begin
                next_st.mode = IODIAG_NORMAL; // see R19
                next_st.pos  = IODIAG_POS_RUN;
              end
              32'h0000_0001, 32'h0000_0002, 32'h0000_0004:
              begin
                // Switching in is accepted even while running; the base cut makes it safe.
                next_st.mode = iodiag_mode_t'(st.data[2:0]); // see R16
                next_st.pos  = IODIAG_POS_RUN;
                if (st.mode == IODIAG_NORMAL)
                begin
                  next_st.base_cut = 1'b1; // see R13
                end
              end
              default:
                next_st.mode = st.mode;
            endcase
          end
        end
        `IODIAG_CMD_POS_CTRL:
        begin
          if (cmd_dno == `IODIAG_DNO_POS_CTRL && st.mode == IODIAG_POSIT)
          begin
            // Each string only acts in the state it belongs to; others are dropped.
            if (st.data == `IODIAG_STR_STOP && st.pos == IODIAG_POS_RUN &&
                pos_motion_active)
            begin
              next_st.pos      = IODIAG_POS_HELD; // see R20, R24
              next_st.pos_stop = 1'b1;
            end
            else if (st.data == `IODIAG_STR_GO && st.pos == IODIAG_POS_HELD)
            begin
              next_st.pos    = IODIAG_POS_RUN; // see R21, R24
              next_st.pos_go = 1'b1;
            end
            else if (st.data == `IODIAG_STR_CLEAR && st.pos == IODIAG_POS_HELD)
            begin
              next_st.pos     = IODIAG_POS_RUN; // see R22, R24
              next_st.pos_clr = 1'b1;
            end
          end
        end
        default:
          next_st.reply = st.reply;
      endcase
    end

    // Effective input devices; disabling keeps only forced stop and stroke ends.
    if (st.mode == IODIAG_NORMAL)
    begin
      next_st.in_eff = (pin_in_dev | st.link_dev) & `IODIAG_IN_DEV_MASK;
    end
    else
    begin
      next_st.in_eff = (pin_in_dev | st.test_dev) & `IODIAG_IN_DEV_MASK;
    end
    if (st.in_off)
    begin
      next_st.in_eff = next_st.in_eff & `IODIAG_IN_KEEP_MASK; // see R9
    end
  end

  // State register.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // Outputs taken straight from state flops.
  assign wb_rsp.ack        = st.ack;
  assign wb_rsp.dat        = st.rdat;
  assign in_dev_effective  = st.in_eff;
  assign analog_zero       = st.in_off; // see R9
  assign pulse_train_block = st.in_off; // see R9
  assign out_dev_enable    = !st.out_off; // see R11
  assign test_mode         = st.mode;
  assign base_cutoff       = st.base_cut;
  assign decel_hold        = st.tmo_stop; // see R14
  assign pos_stop_req      = st.pos_stop;
  assign pos_resume        = st.pos_go;
  assign pos_clear         = st.pos_clr;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_exec(logic [7:0] c, logic [7:0] d);
    exec && cmd_code == c && cmd_dno == d;
  endsequence

  sequence s_cut_pulse;
    base_cutoff ##1 !base_cutoff;
  endsequence

  property p_ack_once;
    access |=> wb_rsp.ack ##1 !wb_rsp.ack;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack not a single pulse");

  property p_in_dev_read;
    s_exec(`IODIAG_CMD_IO_READ, `IODIAG_DNO_IN_DEV) |=>
      st.reply == ($past(st.in_eff) & `IODIAG_IN_DEV_MASK);
  endproperty
  a_in_dev_read: assert property (p_in_dev_read) // see R1
    else $error("input device reply wrong");

  property p_pulse_bits;
    s_exec(`IODIAG_CMD_IO_READ, `IODIAG_DNO_IN_PIN) ##0 pulse_train_sel[0] |=>
      !st.reply[`IODIAG_PULSE_BIT_LO] && st.reply[31:`IODIAG_IN_PIN_W] == '0;
  endproperty
  a_pulse_bits: assert property (p_pulse_bits) // see R3
    else $error("pulse-train pin bit not zero");

  property p_link_write;
    s_exec(`IODIAG_CMD_DEV_WRITE, `IODIAG_DNO_LINK_DEV) |=>
      st.link_dev == ($past(st.data) & `IODIAG_IN_DEV_MASK);
  endproperty
  a_link_write: assert property (p_link_write) // see R7
    else $error("link device map not replaced");

  property p_inputs_off;
    st.in_off |=> (in_dev_effective & ~`IODIAG_IN_KEEP_MASK) == 32'h0000_0000;
  endproperty
  a_inputs_off: assert property (p_inputs_off) // see R9
    else $error("disabled input still on");

  property p_disable_in;
    s_exec(`IODIAG_CMD_DISABLE, `IODIAG_DNO_IN_OFF) ##0 key_ok |=>
      analog_zero ##1 (in_dev_effective & ~`IODIAG_IN_KEEP_MASK) == 32'h0000_0000;
  endproperty
  a_disable_in: assert property (p_disable_in) // see R10
    else $error("input disable not taken");

  property p_disable_out;
    s_exec(`IODIAG_CMD_DISABLE, `IODIAG_DNO_OUT_OFF) ##0 key_ok |=> !out_dev_enable;
  endproperty
  a_disable_out: assert property (p_disable_out) // see R11
    else $error("output disable not taken");

  property p_base_cut;
    s_exec(`IODIAG_CMD_TEST_SEL, `IODIAG_DNO_TEST_SEL) ##0 (st.data == 32'h0000_0002 &&
      test_mode == IODIAG_NORMAL) |=> s_cut_pulse and (test_mode == IODIAG_POSIT);
  endproperty
  a_base_cut: assert property (p_base_cut) // see R13, R16
    else $error("entry to test mode did not cut base");

  property p_timeout_mode;
    decel_hold |-> test_mode != IODIAG_NORMAL && !$past(exec);
  endproperty
  a_timeout_mode: assert property (p_timeout_mode) // see R14
    else $error("timeout stop outside test mode");

  property p_mode_read;
    s_exec(`IODIAG_CMD_READ_MODE, `IODIAG_DNO_READ_MODE) |=>
      st.reply == {29'h0000_0000, $past(st.mode)};
  endproperty
  a_mode_read: assert property (p_mode_read) // see R17
    else $error("mode reply wrong");

  property p_cancel;
    s_exec(`IODIAG_CMD_TEST_SEL, `IODIAG_DNO_TEST_SEL) ##0 (st.data == 32'h0000_0000)
      |=> test_mode == IODIAG_NORMAL ##1 !decel_hold;
  endproperty
  a_cancel: assert property (p_cancel) // see R19
    else $error("cancel did not return to normal");

  property p_stop_hold;
    s_exec(`IODIAG_CMD_POS_CTRL, `IODIAG_DNO_POS_CTRL) ##0 (test_mode == IODIAG_POSIT &&
      st.pos == IODIAG_POS_RUN && pos_motion_active && st.data == `IODIAG_STR_STOP)
      |=> pos_stop_req && st.pos == IODIAG_POS_HELD;
  endproperty
  a_stop_hold: assert property (p_stop_hold) // see R20
    else $error("stop not taken");

  property p_ignore_go;
    exec && st.pos == IODIAG_POS_RUN |=> !pos_resume && !pos_clear;
  endproperty
  a_ignore_go: assert property (p_ignore_go) // see R24
    else $error("go or clear acted while not held");

endmodule

`default_nettype wire

// File: dv/iodiag_master.sv
`timescale 1ns/100ps
`default_nettype none
// Master station model: one classic Wishbone cycle at a time, never pipelined.
module iodiag_master
  import iodiag_pkg::*;
(
  input  wire logic           clk,
  output var iodiag_wb_req_t  wb_req,
  input  wire iodiag_wb_rsp_t wb_rsp
);
  // The bus starts idle with both strobes low.
  initial wb_req = '0;

  // One transfer; ok stays low if no acknowledge arrives within the bound.
  // Released lanes carry inverted values so that stale data cannot pass.
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                      output logic [31:0] rdat, output logic ok);
    int n;
    ok = 1'b0;
    rdat = '0;
    @(posedge clk);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: dat};
    for (n = 0; n < 16 && ok !== 1'b1; n++)
    begin
      @(posedge clk);
      if (wb_rsp.ack === 1'b1)
      begin
        ok = 1'b1;
        rdat = wb_rsp.dat;
      end
    end
    wb_req <= '{cyc: 1'b0, stb: 1'b0, we: ~we, adr: ~adr, sel: 4'h0, dat: ~dat};
  endtask
endmodule
`default_nettype wire

// File: dv/iodiag_test.sv
`include "iodiag_map.svh"
`timescale 1ns/100ps
`default_nettype none
module iodiag_test
  import iodiag_pkg::*;
;
  logic           clk;
  logic           rst_b;
  iodiag_wb_req_t wb_req;
  iodiag_wb_rsp_t wb_rsp;
  logic [11:0]    ext_in_pins;
  logic [1:0]     pulse_train_sel;
  logic [31:0]    pin_in_dev;
  logic [31:0]    core_out_dev;
  logic [8:0]     ext_out_pins;
  logic           pos_motion_active;
  logic [31:0]    in_dev_effective;
  logic           analog_zero;
  logic           pulse_train_block;
  logic           out_dev_enable;
  logic [2:0]     test_mode;
  logic           base_cutoff;
  logic           decel_hold;
  logic           pos_stop_req;
  logic           pos_resume;
  logic           pos_clear;
  logic [31:0]    rd_v;
  int             bad_count;
  int             samples_checked;
  int             n_cut;
  int             n_stop;
  int             n_go;
  int             n_clr;
  int             i;

  // A short watchdog keeps the simulation brief.
  iodiag_top #(.TIMEOUT_CYCLES(50)) i_iodiag_top (
    .clk(clk), .rst_b(rst_b), .wb_req(wb_req), .wb_rsp(wb_rsp),
    .ext_in_pins(ext_in_pins), .pulse_train_sel(pulse_train_sel),
    .pin_in_dev(pin_in_dev), .core_out_dev(core_out_dev),
    .ext_out_pins(ext_out_pins), .pos_motion_active(pos_motion_active),
    .in_dev_effective(in_dev_effective), .analog_zero(analog_zero),
    .pulse_train_block(pulse_train_block), .out_dev_enable(out_dev_enable),
    .test_mode(test_mode), .base_cutoff(base_cutoff), .decel_hold(decel_hold),
    .pos_stop_req(pos_stop_req), .pos_resume(pos_resume), .pos_clear(pos_clear)
  );

  iodiag_master i_iodiag_master (.clk(clk), .wb_req(wb_req), .wb_rsp(wb_rsp));

  // Pulses last one cycle, so they are counted at every edge.
  always @(posedge clk)
  begin
    if (base_cutoff === 1'b1) n_cut++;
    if (pos_stop_req === 1'b1) n_stop++;
    if (pos_resume === 1'b1) n_go++;
    if (pos_clear === 1'b1) n_clr++;
  end

  task automatic conclude();
    if (bad_count == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // A missing acknowledge ends the run at once.
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    logic ok;
    i_iodiag_master.xfer(we, a, d, rd_v, ok);
    if (ok !== 1'b1)
    begin
      bad_count++;
      $display("[ERR] bus ack expected 1 seen %b", ok);
      conclude();
    end
  endtask

  // Command frame; two spare edges let the registered results land.
  task automatic cmd(input logic [7:0] c, input logic [7:0] dn, input logic [31:0] d);
    bus(1'b1, `IODIAG_OFS_CMD, {16'h0, c, dn});
    bus(1'b1, `IODIAG_OFS_DATA, d);
    bus(1'b1, `IODIAG_OFS_EXEC, 32'h0);
    repeat (2) @(posedge clk);
  endtask

  task automatic ask(input logic [7:0] c, input logic [7:0] dn, input string nm,
                     input logic [31:0] e);
    cmd(c, dn, 32'h0);
    bus(1'b0, `IODIAG_OFS_REPLY, 32'h0);
    chk(nm, e, rd_v);
  endtask

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial
  begin
    repeat (30000) @(posedge clk);
    bad_count++;
    $display("[ERR] run expected done seen hang");
    conclude();
  end

  // Main sequence: maps, disables, link bitmaps, modes, positioning, watchdog.
  initial
  begin
    rst_b = 1'b0;
    ext_in_pins = '0;
    pulse_train_sel = '0;
    pin_in_dev = '0;
    core_out_dev = '0;
    ext_out_pins = '0;
    pos_motion_active = 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    ask(8'h00, 8'h12, "mode", 32'h0);
    bus(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h0, rd_v);
    pin_in_dev <= '1;
    ext_in_pins <= '1;
    ext_out_pins <= '1;
    core_out_dev <= '1;
    ask(8'h12, 8'h00, "in_dev", `IODIAG_IN_DEV_MASK);
    ask(8'h12, 8'hc0, "out_pin", 32'h1ff);
    ask(8'h12, 8'h80, "out_dev", `IODIAG_OUT_DEV_MASK);
    for (i = 0; i < 4; i++)
    begin
      pulse_train_sel <= i[1:0];
      ask(8'h12, 8'h40, "in_pin", 32'hfff & ~({30'h0, i[1:0]} << 10));
    end
    cmd(8'h90, 8'h00, 32'h1ea4);
    chk("analog_zero", 32'h0, {31'h0, analog_zero});
    cmd(8'h90, 8'h00, `IODIAG_KEY);
    ask(8'h12, 8'h00, "in_dev_off", `IODIAG_IN_KEEP_MASK);
    chk("pulse_block", 32'h1, {31'h0, pulse_train_block});
    cmd(8'h90, 8'h10, `IODIAG_KEY);
    chk("analog_zero", 32'h0, {31'h0, analog_zero});
    cmd(8'h90, 8'h03, `IODIAG_KEY);
    chk("out_enable", 32'h0, {31'h0, out_dev_enable});
    cmd(8'h90, 8'h13, `IODIAG_KEY);
    chk("out_enable", 32'h1, {31'h0, out_dev_enable});
    pin_in_dev <= '0;
    cmd(8'h92, 8'h60, 32'hffff_ffff);
    ask(8'h12, 8'h60, "link", `IODIAG_IN_DEV_MASK);
    cmd(8'h92, 8'h60, 32'h1);
    ask(8'h12, 8'h60, "link", 32'h1);
    ask(8'h12, 8'h00, "in_dev", 32'h1);
    pos_motion_active <= 1'b1;
    cmd(8'ha0, 8'h41, `IODIAG_STR_STOP);
    chk("stops", 32'h0, n_stop);
    for (i = 1; i < 8; i = i * 2)
    begin
      cmd(8'h8b, 8'h00, i);
      chk("test_mode", i, {29'h0, test_mode});
      ask(8'h00, 8'h12, "mode", i);
      cmd(8'h8b, 8'h00, 32'h0);
      ask(8'h00, 8'h12, "mode", 32'h0);
    end
    chk("cutoffs", 32'h3, n_cut);
    cmd(8'h8b, 8'h00, 32'h3);
    ask(8'h00, 8'h12, "mode", 32'h0);
    cmd(8'h8b, 8'h00, 32'h2);
    cmd(8'h92, 8'h00, 32'h40);
    chk("in_eff", 32'h40, in_dev_effective);
    cmd(8'ha0, 8'h41, `IODIAG_STR_STOP);
    chk("stops", 32'h1, n_stop);
    cmd(8'ha0, 8'h41, `IODIAG_STR_STOP);
    chk("stops", 32'h1, n_stop);
    cmd(8'ha0, 8'h41, `IODIAG_STR_GO);
    chk("resumes", 32'h1, n_go);
    cmd(8'ha0, 8'h41, `IODIAG_STR_STOP);
    cmd(8'ha0, 8'h41, `IODIAG_STR_CLEAR);
    chk("clears", 32'h1, n_clr);
    cmd(8'ha0, 8'h41, `IODIAG_STR_GO);
    chk("resumes", 32'h1, n_go);
    // Traffic stops on purpose so that the watchdog expires.
    repeat (20) @(posedge clk);
    chk("decel", 32'h0, {31'h0, decel_hold});
    repeat (50) @(posedge clk);
    chk("decel", 32'h1, {31'h0, decel_hold});
    bus(1'b0, `IODIAG_OFS_STATUS, 32'h0);
    chk("status", 32'h802, rd_v);
    cmd(8'h8b, 8'h00, 32'h0);
    chk("decel", 32'h0, {31'h0, decel_hold});
    chk("test_mode", 32'h0, {29'h0, test_mode});
    conclude();
  end
endmodule
`default_nettype wire
